/* shared/ucg_pkg.sv */
package ucg_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam logic [7:0] UPPER_CHANNEL_GAIN_OFS = 8'h05;
  localparam logic [7:0] GENERAL_SETUP_OFS = 8'h06;
  localparam logic [15:0] UPPER_CHANNEL_GAIN_RST = 16'h0000;
  localparam logic [15:0] GENERAL_SETUP_RST = 16'h0600;
  // Writable bits: the four 3-bit gain fields
  localparam logic [15:0] GAIN_WR_MASK = 16'h7777;
  localparam int CH7_LSB = 12;
  localparam int CH6_LSB = 8;
  localparam int CH5_LSB = 4;
  localparam int CH4_LSB = 0;
  localparam int GAIN_W = 3;
  localparam logic [2:0] GAIN_CODE_RST = 3'h0;

  typedef struct packed {
    logic [2:0] ampGainCh7;
    logic [2:0] ampGainCh6;
    logic [2:0] ampGainCh5;
    logic [2:0] ampGainCh4;
  } ucg_gains_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } ucg_req_type;
endpackage

/* verilog/ucg_regs.sv */
// Summary of operation
// R1: Gain register for channels 4-7 at address 5h, resets to 0000h.
// R2: Bits 14:12 set channel 7 gain, code n gives gain 2^n, reset 0.
// R3: Bits 10:8 set channel 6 gain, same encoding, reset 0.
// R4: Bits 6:4 set channel 5 gain, same encoding, reset 0.
// R5: Bits 2:0 set channel 4 gain, same encoding, reset 0.
// R6: General configuration register at address 06h, resets to 0600h.
// R7: Reserved gain bits 15,11,7,3 are written zero and read zero.
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module ucg_regs
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register port
  input wire ucg_pkg::ucg_req_type busReq,
  output logic [15:0] rdData,
  // Gain codes to the analog front end
  output ucg_pkg::ucg_gains_type gains
);

  ////////////////////////////////////////////////////////////////////////////
  // Field layout
  // Index 0 is channel 4, index 3 is channel 7
  localparam int NUM_CH = 4;

  localparam int FIELD_LSB [NUM_CH] = '{
    ucg_pkg::CH4_LSB,
    ucg_pkg::CH5_LSB,
    ucg_pkg::CH6_LSB,
    ucg_pkg::CH7_LSB
  };

  // Source of the next read data word
  typedef enum logic [1:0]
  {
    RD_NONE,
    RD_GAIN,
    RD_SETUP,
    RD_UNMAPPED
  } ucg_rdsel_type;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode signals
  logic gainHit;
  logic setupHit;
  logic gainWr;
  logic setupWr;
  logic gainRd;
  logic setupRd;

  // Gain storage
  logic [ucg_pkg::GAIN_W-1:0] gainCode_r [NUM_CH];
  logic [ucg_pkg::GAIN_W-1:0] gainCode_nxt [NUM_CH];
  logic [15:0] gainView;

  // Setup storage
  logic [15:0] setupReg_r;
  logic [15:0] setupReg_nxt;

  // Read path
  ucg_rdsel_type rdSel;
  logic [15:0] rdData_r;
  logic [15:0] rdData_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // One compare per register, shared by both strobes
  always_comb
  begin
    gainHit = 1'b0;
    setupHit = 1'b0;
    if (busReq.addr == ucg_pkg::UPPER_CHANNEL_GAIN_OFS)
    begin
      gainHit = 1'b1; // R1
    end
    else if (busReq.addr == ucg_pkg::GENERAL_SETUP_OFS)
    begin
      setupHit = 1'b1; // R6
    end
  end

  // The bus never raises both strobes, so no priority is needed
  always_comb
  begin
    gainWr = busReq.wr && gainHit;
    setupWr = busReq.wr && setupHit;
    gainRd = busReq.rd && gainHit;
    setupRd = busReq.rd && setupHit;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gain fields: next value
  always_comb
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      gainCode_nxt[i] = gainCode_r[i];
    end
    if (gainWr)
    begin
      // Reserved bits between fields are never stored
      for (int i = 0; i < NUM_CH; i++)
      begin
        gainCode_nxt[i] =
          busReq.wdata[FIELD_LSB[i] +: ucg_pkg::GAIN_W]; // R2 R3 R4 R5
      end
    end
  end

  // Gain fields: registers
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        gainCode_r[i] <= ucg_pkg::GAIN_CODE_RST; // R1
      end
    end
    else
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        gainCode_r[i] <= gainCode_nxt[i];
      end
    end
  end

  // Register image as software sees it
  always_comb
  begin
    gainView = 16'h0000;
    for (int i = 0; i < NUM_CH; i++)
    begin
      gainView[FIELD_LSB[i] +: ucg_pkg::GAIN_W] = gainCode_r[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Setup register: stored whole, used only for read-back, it drives no output
  always_comb
  begin
    setupReg_nxt = setupReg_r;
    if (setupWr)
    begin
      setupReg_nxt = busReq.wdata; // R6
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      setupReg_r <= ucg_pkg::GENERAL_SETUP_RST; // R6
    end
    else
    begin
      setupReg_r <= setupReg_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read source select
  always_comb
  begin
    rdSel = RD_NONE;
    if (gainRd)
    begin
      rdSel = RD_GAIN;
    end
    else if (setupRd)
    begin
      rdSel = RD_SETUP;
    end
    else if (busReq.rd)
    begin
      rdSel = RD_UNMAPPED;
    end
  end

  // Read data stands one cycle, then returns to zero
  always_comb
  begin
    rdData_nxt = 16'h0000;
    case (rdSel)
      RD_GAIN:
      begin
        // Mask kept as a guard on the reserved positions
        rdData_nxt = gainView & ucg_pkg::GAIN_WR_MASK; // R1
      end
      RD_SETUP:
      begin
        rdData_nxt = setupReg_r; // R6
      end
      default:
      begin
        // Idle and unmapped reads both give zero
        rdData_nxt = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdData_r <= 16'h0000;
    end
    else
    begin
      rdData_r <= rdData_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flip-flops
  assign rdData = rdData_r;

  assign gains.ampGainCh7 = gainCode_r[3]; // R2

  assign gains.ampGainCh6 = gainCode_r[2]; // R3

  assign gains.ampGainCh5 = gainCode_r[1]; // R4

  assign gains.ampGainCh4 = gainCode_r[0]; // R5

endmodule
`default_nettype wire

/* dv/ucg_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module ucg_asserts
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Observed ports
  input wire ucg_pkg::ucg_req_type busReq,
  input wire logic [15:0] rdData,
  input wire ucg_pkg::ucg_gains_type gains
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  chk_gain_write: assert property (
    busReq.wr && busReq.addr == 8'h05 |=>
    gains == {$past(busReq.wdata[14:12]), $past(busReq.wdata[10:8]),
    $past(busReq.wdata[6:4]), $past(busReq.wdata[2:0])})
    else $error("gain codes differ from written fields");

  chk_gain_hold: assert property (
    !(busReq.wr && busReq.addr == 8'h05) |=> $stable(gains))
    else $error("gain codes changed without a write");

  chk_read_gain: assert property (
    busReq.rd && busReq.addr == 8'h05 |=>
    rdData == {1'b0, $past(gains.ampGainCh7), 1'b0, $past(gains.ampGainCh6),
    1'b0, $past(gains.ampGainCh5), 1'b0, $past(gains.ampGainCh4)})
    else $error("gain register read data wrong");

  chk_read_idle: assert property (
    !busReq.rd |=> rdData == 16'h0000)
    else $error("read data not zero without a read");

  chk_read_unmapped: assert property (
    busReq.rd && busReq.addr != 8'h05 && busReq.addr != 8'h06 |=>
    rdData == 16'h0000)
    else $error("unmapped read not zero");

  chk_setup_back: assert property (
    (busReq.wr && busReq.addr == 8'h06) ##1
    (busReq.rd && busReq.addr == 8'h06) |=>
    rdData == $past(busReq.wdata, 2))
    else $error("setup register read after write wrong");

  chk_reset_values: assert property (disable iff (1'b0)
    !rst_n |-> gains == '0 && rdData == 16'h0000)
    else $error("outputs not cleared in reset");
endmodule

bind ucg_regs ucg_asserts ucg_asserts_i
(
  .ref_clk(ref_clk),
  .rst_n(rst_n),
  .busReq(busReq),
  .rdData(rdData),
  .gains(gains)
);
`default_nettype wire

/* dv/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b1;
  ucg_pkg::ucg_req_type busReq = '0;
  logic [15:0] rdData;
  ucg_pkg::ucg_gains_type gains;
  int numErrors = 0;
  int comparisons = 0;
  // Row: wr, rd, addr, wdata, expected read data, expected gain codes
  logic [53:0] rows [14];

  ucg_regs ucg_regs_i
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .busReq(busReq),
    .rdData(rdData),
    .gains(gains)
  );

  initial
  begin
    forever
    begin
      #50 ref_clk = ~ref_clk;
    end
  end

  task automatic checkRd(input logic [15:0] expVal);
    comparisons++;
    if (rdData !== expVal)
    begin
      numErrors++;
      $display("wrong value rdData expected %h seen %h", expVal, rdData);
    end
  endtask

  task automatic checkGains(input logic [11:0] expVal);
    comparisons++;
    if (gains !== expVal)
    begin
      numErrors++;
      $display("wrong value gains expected %h seen %h", expVal, gains);
    end
  endtask

  task automatic drive(input ucg_pkg::ucg_req_type q);
    @(posedge ref_clk);
    busReq <= q;
  endtask

  task automatic runRow(input logic [53:0] r);
    drive('{addr: r[51:44], wdata: r[43:28], wr: r[53], rd: r[52]});
    drive('0);
    @(negedge ref_clk);
    checkRd(r[27:12]);
    checkGains(r[11:0]);
  endtask

  task automatic stopTest();
    if (numErrors == 0 && comparisons > 0)
    begin
      $display("Testbench passed");
    end
    else
    begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Tests take about 47 cycles; the limit leaves a wide margin
  initial
  begin
    #100000;
    numErrors++;
    stopTest();
  end

  initial
  begin
    // Writes keep the reserved bits at zero
    rows = '{
      {1'b0, 1'b1, 8'h05, 16'h0000, 16'h0000, 12'h000},
      {1'b0, 1'b1, 8'h06, 16'h0000, 16'h0600, 12'h000},
      {1'b1, 1'b0, 8'h05, 16'h7777, 16'h0000, 12'hfff},
      {1'b0, 1'b1, 8'h05, 16'h0000, 16'h7777, 12'hfff},
      {1'b1, 1'b0, 8'h05, 16'h1234, 16'h0000, 12'h29c},
      {1'b0, 1'b1, 8'h05, 16'h0000, 16'h1234, 12'h29c},
      {1'b1, 1'b0, 8'h05, 16'h0567, 16'h0000, 12'h177},
      {1'b0, 1'b1, 8'h05, 16'h0000, 16'h0567, 12'h177},
      {1'b1, 1'b0, 8'h06, 16'ha5c3, 16'h0000, 12'h177},
      {1'b0, 1'b1, 8'h06, 16'h0000, 16'ha5c3, 12'h177},
      {1'b1, 1'b0, 8'h03, 16'h7777, 16'h0000, 12'h177},
      {1'b0, 1'b1, 8'h03, 16'h0000, 16'h0000, 12'h177},
      {1'b0, 1'b1, 8'h05, 16'h0000, 16'h0567, 12'h177},
      {1'b0, 1'b1, 8'h07, 16'h0000, 16'h0000, 12'h177}
    };
    rst_n <= 1'b0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    checkRd(16'h0000);
    checkGains(12'h000);
    foreach (rows[i])
    begin
      runRow(rows[i]);
    end
    // Read right after a write returns the new value
    drive('{addr: 8'h05, wdata: 16'h0123, wr: 1'b1, rd: 1'b0});
    drive('{addr: 8'h05, wdata: 16'h0000, wr: 1'b0, rd: 1'b1});
    drive('0);
    @(negedge ref_clk);
    checkRd(16'h0123);
    checkGains(12'h053);
    drive('{addr: 8'h06, wdata: 16'h0f0f, wr: 1'b1, rd: 1'b0});
    drive('{addr: 8'h06, wdata: 16'h0000, wr: 1'b0, rd: 1'b1});
    drive('0);
    @(negedge ref_clk);
    checkRd(16'h0f0f);
    // Reset in mid-run restores both registers
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    checkRd(16'h0000);
    checkGains(12'h000);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    runRow({1'b0, 1'b1, 8'h05, 16'h0000, 16'h0000, 12'h000});
    runRow({1'b0, 1'b1, 8'h06, 16'h0000, 16'h0600, 12'h000});
    stopTest();
  end
endmodule
`default_nettype wire
